// file: pin_function_config.sv
// Pin function, guardband and supply-enable output mode logic
`timescale 1ns/1ps
`default_nettype none

module pin_function_config
	import pin_function_pkg::*;
#(
	parameter int RST_BASE_CYCLES = RST_TO_BASE_CYC
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        multi_pin_four,
	input  wire logic        multi_pin_five,
	input  wire logic        multi_pin_six,
	output logic             multi_pin_six_out,
	output logic             multi_pin_six_oe,
	input  wire logic        watchdog_timeout,
	output logic             watchdog_service_in,
	input  wire logic        fault_line_a_raw,
	input  wire logic        fault_line_b_raw,
	input  wire logic        any_fault_raw,
	input  wire logic        seq_reset_raw,
	input  wire logic        threshold_violation,
	input  wire logic        fault_log_req,
	output logic             fault_line_a,
	output logic             fault_line_b,
	output logic             any_fault,
	output logic             reset_out,
	output logic             threshold_violation_eff,
	output logic             fault_log_write,
	output logic             guardband_active,
	input  wire logic [8:0]  enable_req,
	output logic      [8:0]  enable_out,
	output logic      [8:0]  enable_oe,
	output logic      [3:0]  track_sel,
	output logic      [5:0]  pump_sel
);

	////////////////////////////////////////////////////////////////////////
	// Registers and APB slave
	logic [7:0] enable_out_mode_a_reg;
	logic [7:0] enable_out_mode_b_reg;
	logic [7:0] enable_out_mode_c_reg;
	logic [7:0] rst_cfg_reg;
	logic [7:0] wd_sel_a_reg;
	logic [7:0] wd_sel_b_reg;
	logic [7:0] sw_ctrl_reg;
	logic       wr_en;
	logic       mapped;

	assign pready = 1'b1;
	assign wr_en  = psel && penable && pwrite && pstrb[0];

	always_comb
	begin
		unique case (paddr)
			ADDR_MODE_A, ADDR_MODE_B, ADDR_MODE_C, ADDR_RST_CFG,
			ADDR_WD_SEL_A, ADDR_WD_SEL_B, ADDR_SW_CTRL, ADDR_STATUS:
				mapped = 1'b1;
			default:
				mapped = 1'b0;
		endcase
	end

	assign pslverr = psel && penable && !mapped;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			enable_out_mode_a_reg <= MODE_A_RESET;
			enable_out_mode_b_reg <= MODE_B_RESET;
			enable_out_mode_c_reg <= MODE_C_RESET;
			rst_cfg_reg           <= RST_CFG_RESET;
			wd_sel_a_reg          <= 8'h00;
			wd_sel_b_reg          <= 8'h00;
			sw_ctrl_reg           <= 8'h00;
		end
		else if (wr_en)
		begin
			unique case (paddr)
				ADDR_MODE_A:   enable_out_mode_a_reg <= pwdata[7:0];
				ADDR_MODE_B:   enable_out_mode_b_reg <= pwdata[7:0];
				ADDR_MODE_C:   enable_out_mode_c_reg <= pwdata[7:0];
				ADDR_RST_CFG:  rst_cfg_reg           <= pwdata[7:0];
				ADDR_WD_SEL_A: wd_sel_a_reg          <= pwdata[7:0];
				ADDR_WD_SEL_B: wd_sel_b_reg          <= pwdata[7:0];
				ADDR_SW_CTRL:  sw_ctrl_reg           <= pwdata[7:0];
				default:       ;
			endcase
		end
	end

	logic [7:0] status_byte;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite)
		begin
			unique case (paddr)
				ADDR_MODE_A:   prdata <= {24'h000000, enable_out_mode_a_reg};
				ADDR_MODE_B:   prdata <= {24'h000000, enable_out_mode_b_reg};
				ADDR_MODE_C:   prdata <= {24'h000000, enable_out_mode_c_reg};
				ADDR_RST_CFG:  prdata <= {24'h000000, rst_cfg_reg};
				ADDR_WD_SEL_A: prdata <= {24'h000000, wd_sel_a_reg};
				ADDR_WD_SEL_B: prdata <= {24'h000000, wd_sel_b_reg};
				ADDR_SW_CTRL:  prdata <= {24'h000000, sw_ctrl_reg};
				ADDR_STATUS:   prdata <= {24'h000000, status_byte};
				default:       prdata <= 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_meta <= 3'h7;
			pin_sync <= 3'h7;
		end
		else
		begin
			pin_meta <= {multi_pin_six, multi_pin_five, multi_pin_four};
			pin_sync <= pin_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin function selection
	logic wdo_sel;
	logic wdi_sel;

	// Pin six is the guardband hold input unless routed to watchdog
	assign wdo_sel = {wd_sel_b_reg[1:0], wd_sel_a_reg[WDO_SEL_BIT]}
		== WDO_PATTERN;
	assign wdi_sel = wd_sel_a_reg[WDI_SEL_LSB +: 3] == WDI_PATTERN;

	assign watchdog_service_in = wdi_sel && pin_sync[1];
	// Open drain: drive low only while timed out
	assign multi_pin_six_out = 1'b0;
	assign multi_pin_six_oe  = wdo_sel && watchdog_timeout;

	////////////////////////////////////////////////////////////////////////
	// Guardband freeze
	logic hold_low;

	assign hold_low = !wdo_sel && !pin_sync[2];
	assign guardband_active = hold_low || sw_ctrl_reg[SW_GUARD_BIT];

	logic reset_int;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fault_line_a <= 1'b0;
			fault_line_b <= 1'b0;
			any_fault    <= 1'b0;
			reset_out    <= 1'b1;
		end
		else if (!guardband_active)
		begin
			fault_line_a <= fault_line_a_raw;
			fault_line_b <= fault_line_b_raw;
			any_fault    <= any_fault_raw;
			reset_out    <= reset_int;
		end
	end

	assign threshold_violation_eff = threshold_violation && !guardband_active;
	assign fault_log_write = fault_log_req && !guardband_active;

	////////////////////////////////////////////////////////////////////////
	// Manual reset stretch
	rst_state_t rst_state_reg;
	logic [31:0] rst_cnt_reg;
	logic [31:0] rst_period;
	logic        mr_low;

	// Timeout code scales the base period by a power of two
	assign rst_period = 32'(RST_BASE_CYCLES) << rst_cfg_reg[RST_TO_LSB +: 3];
	assign mr_low = !pin_sync[0];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rst_state_reg <= RST_IDLE;
			rst_cnt_reg   <= 32'h00000000;
		end
		else
		begin
			unique case (rst_state_reg)
				RST_IDLE:
					if (mr_low)
					begin
						rst_state_reg <= RST_HOLD;
						rst_cnt_reg   <= 32'h00000000;
					end
				RST_HOLD:
					if (mr_low)
						rst_cnt_reg <= 32'h00000000;
					else if (rst_cnt_reg >= rst_period - 32'h00000001)
						rst_state_reg <= RST_IDLE;
					else
						rst_cnt_reg <= rst_cnt_reg + 32'h00000001;
			endcase
		end
	end

	assign reset_int = seq_reset_raw || (rst_state_reg == RST_HOLD) || mr_low;

	////////////////////////////////////////////////////////////////////////
	// Supply-enable output modes
	logic [2:0] mode [0:8];

	assign mode[0] = enable_out_mode_a_reg[2:0];
	assign mode[1] = enable_out_mode_a_reg[5:3];
	assign mode[2] = {enable_out_mode_b_reg[0], enable_out_mode_a_reg[7:6]};
	assign mode[3] = enable_out_mode_b_reg[3:1];
	assign mode[4] = enable_out_mode_b_reg[6:4];
	assign mode[5] = {enable_out_mode_c_reg[1:0], enable_out_mode_b_reg[7]};
	assign mode[6] = {1'b0, enable_out_mode_c_reg[3:2]};
	assign mode[7] = {1'b0, enable_out_mode_c_reg[5:4]};
	assign mode[8] = {1'b0, enable_out_mode_c_reg[7:6]};

	genvar gi;
	generate
		for (gi = 0; gi < 9; gi++)
		begin : g_out
			logic hi_act;
			logic lvl;
			logic track;
			logic pump;
			logic legal;

			assign track = (gi < 4) && mode[gi] == MODE_TRACK;
			assign pump  = (gi < 6) && mode[gi] == MODE_PUMP;
			assign legal = mode[gi][2] == 1'b0 || track || pump;
			assign hi_act = mode[gi][0] || track || pump;
			assign lvl = hi_act ? enable_req[gi] : !enable_req[gi];

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					enable_out[gi] <= 1'b0;
					enable_oe[gi]  <= 1'b0;
				end
				else if (!legal)
				begin
					enable_out[gi] <= 1'b0;
					enable_oe[gi]  <= 1'b0;
				end
				else if (mode[gi][1] || track || pump)
				begin
					enable_out[gi] <= lvl;
					enable_oe[gi]  <= 1'b1;
				end
				else
				begin
					enable_out[gi] <= 1'b0;
					enable_oe[gi]  <= !lvl;
				end
			end

			if (gi < 4)
			begin : g_trk
				assign track_sel[gi] = track;
			end
			if (gi < 6)
			begin : g_pmp
				assign pump_sel[gi] = pump;
			end
		end
	endgenerate

	assign status_byte = {2'b00, wdi_sel, wdo_sel, rst_state_reg == RST_HOLD,
		reset_out, hold_low, guardband_active};

	////////////////////////////////////////////////////////////////////////
	// Checks
	chk_guard_freeze: assert property (
		@(posedge pclk) disable iff (!presetn)
		guardband_active |=>
		$stable({reset_out, any_fault, fault_line_b, fault_line_a}))
		else $error("outputs changed during guardband");
	chk_guard_log: assert property (
		@(posedge pclk) disable iff (!presetn)
		guardband_active |-> !fault_log_write && !threshold_violation_eff)
		else $error("fault logged during guardband");
	chk_sw_guard: assert property (
		@(posedge pclk) disable iff (!presetn)
		sw_ctrl_reg[SW_GUARD_BIT] |-> guardband_active)
		else $error("software guard ignored");
	chk_mr_hold: assert property (
		@(posedge pclk) disable iff (!presetn)
		mr_low |=> rst_state_reg == RST_HOLD)
		else $error("manual reset not held");
	chk_mr_stretch: assert property (
		@(posedge pclk) disable iff (!presetn)
		$fell(mr_low) |-> rst_state_reg == RST_HOLD [*2])
		else $error("reset released early");
	chk_wdo_drive: assert property (
		@(posedge pclk) disable iff (!presetn)
		multi_pin_six_oe |-> wdo_sel && !multi_pin_six_out)
		else $error("watchdog pin misdriven");
	chk_wdi_gate: assert property (
		@(posedge pclk) disable iff (!presetn)
		!wdi_sel |-> !watchdog_service_in)
		else $error("service input not gated");
	chk_reserved_hiz: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode[4] == MODE_TRACK |=> !enable_oe[4])
		else $error("reserved mode drives output");
	chk_track_sel: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode[0] == MODE_TRACK |-> track_sel[0])
		else $error("tracking not selected");
	chk_code_hiz: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode[0][2:1] == 2'b11 |=> !enable_oe[0])
		else $error("reserved code drives output");

	cov_guard: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(guardband_active));
	cov_mr: cover property (@(posedge pclk) disable iff (!presetn)
		$fell(rst_state_reg == RST_HOLD));
	cov_wdo: cover property (@(posedge pclk) disable iff (!presetn)
		multi_pin_six_oe);
	cov_pump: cover property (@(posedge pclk) disable iff (!presetn)
		|pump_sel);

endmodule // pin_function_config

`default_nettype wire

// file: pin_function_pkg.sv
// Constants for the supervisor pin function configuration block
package pin_function_pkg;

	// Register indices; the bus address is four times the index
	localparam logic [9:0]  IDX_MODE_A    = 10'h01F;
	localparam logic [9:0]  IDX_MODE_B    = 10'h020;
	localparam logic [9:0]  IDX_MODE_C    = 10'h021;
	localparam logic [9:0]  IDX_RST_CFG   = 10'h019;
	localparam logic [9:0]  IDX_WD_SEL_A  = 10'h01D;
	localparam logic [9:0]  IDX_WD_SEL_B  = 10'h01E;
	localparam logic [9:0]  IDX_SW_CTRL   = 10'h04D;
	localparam logic [9:0]  IDX_STATUS    = 10'h080;

	localparam logic [11:0] ADDR_MODE_A   = {IDX_MODE_A, 2'b00};
	localparam logic [11:0] ADDR_MODE_B   = {IDX_MODE_B, 2'b00};
	localparam logic [11:0] ADDR_MODE_C   = {IDX_MODE_C, 2'b00};
	localparam logic [11:0] ADDR_RST_CFG  = {IDX_RST_CFG, 2'b00};
	localparam logic [11:0] ADDR_WD_SEL_A = {IDX_WD_SEL_A, 2'b00};
	localparam logic [11:0] ADDR_WD_SEL_B = {IDX_WD_SEL_B, 2'b00};
	localparam logic [11:0] ADDR_SW_CTRL  = {IDX_SW_CTRL, 2'b00};
	localparam logic [11:0] ADDR_STATUS   = {IDX_STATUS, 2'b00};

	localparam int RST_TO_LSB    = 4;
	localparam int SW_GUARD_BIT  = 1;
	localparam int WDO_SEL_BIT   = 7;
	localparam int WDI_SEL_LSB   = 4;
	localparam logic [2:0] WDO_PATTERN = 3'h6;
	localparam logic [2:0] WDI_PATTERN = 3'h7;

	localparam logic [2:0] MODE_OD_LOW  = 3'h0;
	localparam logic [2:0] MODE_OD_HIGH = 3'h1;
	localparam logic [2:0] MODE_PP_LOW  = 3'h2;
	localparam logic [2:0] MODE_PP_HIGH = 3'h3;
	localparam logic [2:0] MODE_TRACK   = 3'h4;
	localparam logic [2:0] MODE_PUMP    = 3'h5;

	localparam logic [7:0] MODE_A_RESET = 8'h00;
	localparam logic [7:0] MODE_B_RESET = 8'h00;
	localparam logic [7:0] MODE_C_RESET = 8'h00;
	localparam logic [7:0] RST_CFG_RESET = 8'h00;

	localparam int CLK_MHZ = 100;
	localparam int RST_TO_BASE_US = 25;
	localparam int RST_TO_BASE_CYC = RST_TO_BASE_US * CLK_MHZ;

	typedef enum logic [1:0] {
		RST_IDLE = 2'b01,
		RST_HOLD = 2'b10
	} rst_state_t;

endpackage

// file: supervisor_pin_function_config_test.sv
// Testbench for the pin function configuration block
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_compared++; \
	if ((g) !== (e)) begin miscompares++; \
	$display("unexpected %s exp %0h got %0h", nm, e, g); end end

module supervisor_pin_function_config_test;
	import pin_function_pkg::*;
	localparam int BASE = 4;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb, flt;
	logic [1:0]  evt;
	logic        p4, p5, p6, six_out, six_oe, wdt, svc, err;
	logic        fa, fb, af, rst, thr_eff, log_wr, guard;
	logic [8:0]  req, en_out, en_oe;
	logic [3:0]  trk;
	logic [5:0]  pmp;
	int          miscompares, n_compared;

	pin_function_config #(.RST_BASE_CYCLES(BASE)) u_pin_function_config (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.multi_pin_four(p4), .multi_pin_five(p5), .multi_pin_six(p6),
		.multi_pin_six_out(six_out), .multi_pin_six_oe(six_oe),
		.watchdog_timeout(wdt), .watchdog_service_in(svc),
		.fault_line_a_raw(flt[0]), .fault_line_b_raw(flt[1]),
		.any_fault_raw(flt[2]), .seq_reset_raw(flt[3]),
		.threshold_violation(evt[0]), .fault_log_req(evt[1]),
		.fault_line_a(fa), .fault_line_b(fb), .any_fault(af),
		.reset_out(rst), .threshold_violation_eff(thr_eff),
		.fault_log_write(log_wr), .guardband_active(guard),
		.enable_req(req), .enable_out(en_out), .enable_oe(en_oe),
		.track_sel(trk), .pump_sel(pmp));

	supply_host_model u_supply_host_model (
		.pclk(pclk), .six_oe(six_oe), .pin_four(p4), .pin_five(p5),
		.pin_six(p6), .flt(flt), .evt(evt), .req(req), .wdt(wdt));

	////////////////////////////////////////////////////////////////////
	task wrap_up();
		if (miscompares == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task wt(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Returns {out checked, out level, oe}
	function automatic logic [2:0] exp_pin(input int i, input logic [2:0] c,
		input logic q);
		if (c[2:1] == 2'b11 || (c == MODE_TRACK && i >= 4))
			return 3'b000;
		case (c)
			MODE_OD_LOW:  return {2'b10, q};
			MODE_OD_HIGH: return {2'b10, !q};
			MODE_PP_LOW:  return {1'b1, !q, 1'b1};
			default:      return {1'b1, q, 1'b1};
		endcase
	endfunction

	task automatic run_modes(input logic [23:0] v);
		logic [2:0] c, e;
		apb(1'b1, ADDR_MODE_A, {24'h0, v[7:0]});
		apb(1'b1, ADDR_MODE_B, {24'h0, v[15:8]});
		apb(1'b1, ADDR_MODE_C, {24'h0, v[23:16]});
		apb(1'b0, ADDR_MODE_B, 32'h0);
		`CHK("mode_b", {24'h0, v[15:8]}, rd)
		for (int r = 0; r < 2; r++)
		begin
			u_supply_host_model.set_req({9{r[0]}});
			wt(3);
			for (int i = 0; i < 9; i++)
			begin
				c = (i < 6) ? v[i*3 +: 3] : {1'b0, v[18+(i-6)*2 +: 2]};
				e = exp_pin(i, c, r[0]);
				if (e[2]) `CHK("enable_out", e[1], en_out[i])
				`CHK("enable_oe", e[0], en_oe[i])
				if (i < 4) `CHK("track_sel", c == MODE_TRACK, trk[i])
				if (i < 6) `CHK("pump_sel", c == MODE_PUMP, pmp[i])
			end
		end
	endtask

	////////////////////////////////////////////////////////////////////
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		wrap_up();
	end

	initial
	begin
		logic [2:0]  c;
		int          n;
		logic [11:0] ma [3];
		logic [7:0]  wa [3];
		logic [1:0]  wb [3];
		logic        wo [3];
		logic        wi [3];
		ma = '{ADDR_MODE_A, ADDR_MODE_B, ADDR_MODE_C};
		wa = '{8'h70, 8'hF0, 8'h60};
		wb = '{2'h3, 2'h3, 2'h2};
		wo = '{1'b1, 1'b0, 1'b0};
		wi = '{1'b1, 1'b1, 1'b0};
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		miscompares = 0;
		n_compared = 0;
		wt(10);
		presetn <= 1'b1;
		for (int k = 0; k < 3; k++)
		begin
			apb(1'b0, ma[k], 32'h0);
			`CHK("mode_reset", 32'h0, rd)
		end
		apb(1'b0, 12'h0F0, 32'h0);
		`CHK("pslverr", 1'b1, err)
		pstrb <= 4'h0;
		apb(1'b1, ADDR_MODE_A, 32'h000000FF);
		pstrb <= 4'hF;
		apb(1'b0, ADDR_MODE_A, 32'h0);
		`CHK("strobe_off", 32'h0, rd)
		for (int k = 0; k < 8; k++)
		begin
			c = k[2:0];
			run_modes({c[1:0], c[1:0], c[1:0], c, c, c, c, c, c});
		end
		run_modes({2'h3, 2'h2, 2'h1, 3'h4, 3'h3, 3'h5, 3'h4, 3'h2, 3'h1});
		for (int m = 0; m < 2; m++)
		begin
			u_supply_host_model.set_flt(4'h5);
			u_supply_host_model.set_evt(m ? 2'h1 : 2'h3);
			wt(4);
			`CHK("fault_log_write", m == 0, log_wr)
			`CHK("threshold_eff", 1'b1, thr_eff)
			if (m == 0)
				u_supply_host_model.excursion(1'b1);
			else
				apb(1'b1, ADDR_SW_CTRL, 32'h2);
			u_supply_host_model.set_flt(4'hA);
			wt(4);
			`CHK("guardband_active", 1'b1, guard)
			`CHK("frozen", 4'h5, {rst, af, fb, fa})
			`CHK("threshold_eff", 1'b0, thr_eff)
			`CHK("fault_log_write", 1'b0, log_wr)
			apb(1'b0, ADDR_STATUS, 32'h0);
			`CHK("status", (m == 0) ? 32'h3 : 32'h1, rd)
			if (m == 0)
				u_supply_host_model.excursion(1'b0);
			else
				apb(1'b1, ADDR_SW_CTRL, 32'h0);
			wt(4);
			`CHK("released", 4'hA, {rst, af, fb, fa})
		end
		u_supply_host_model.set_flt(4'h5);
		for (int k = 0; k < 2; k++)
		begin
			c = 3'(k * 3);
			apb(1'b1, ADDR_RST_CFG, {25'h0, c, 4'h0});
			u_supply_host_model.set_pins(1'b0, 1'b1);
			wt(5);
			`CHK("reset_out", 1'b1, rst)
			u_supply_host_model.set_pins(1'b1, 1'b1);
			n = 0;
			while (rst === 1'b1 && n < 300)
			begin
				wt(1);
				n++;
			end
			`CHK("reset_hold", 1'b1, n >= (BASE << c) && n <= (BASE << c) + 6)
		end
		for (int k = 0; k < 3; k++)
		begin
			apb(1'b1, ADDR_WD_SEL_A, {24'h0, wa[k]});
			apb(1'b1, ADDR_WD_SEL_B, {30'h0, wb[k]});
			u_supply_host_model.set_wdt(1'b1);
			u_supply_host_model.set_pins(1'b1, 1'b1);
			wt(4);
			`CHK("six_oe", wo[k], six_oe)
			`CHK("six_out", 1'b0, six_out)
			`CHK("service_in", wi[k], svc)
			u_supply_host_model.set_wdt(1'b0);
			u_supply_host_model.set_pins(1'b1, 1'b0);
			wt(4);
			`CHK("six_oe", 1'b0, six_oe)
			`CHK("service_in", 1'b0, svc)
		end
		wrap_up();
	end
endmodule // supervisor_pin_function_config_test

`default_nettype wire

// file: supply_host_model.sv
// Far-side model: supplies, host pins and fault sources
`timescale 1ns/1ps
`default_nettype none

module supply_host_model
(
	input  wire logic       pclk,
	input  wire logic       six_oe,
	output var  logic       pin_four,
	output var  logic       pin_five,
	output logic            pin_six,
	output var  logic [3:0] flt,
	output var  logic [1:0] evt,
	output var  logic [8:0] req,
	output var  logic       wdt
);
	logic hold_n;

	initial
	begin
		hold_n = 1'b1;
		pin_four = 1'b1;
		pin_five = 1'b0;
		flt = 4'h0;
		evt = 2'h0;
		req = 9'h000;
		wdt = 1'b0;
	end

	// Open-drain wire with pull-up; device pulls low when enabled
	assign pin_six = six_oe ? 1'b0 : hold_n;

	////////////////////////////////////////////////////////////////////
	task set_pins(input logic mr_n, input logic svc);
		pin_four <= mr_n;
		pin_five <= svc;
	endtask

	task set_flt(input logic [3:0] v);
		flt <= v;
	endtask

	task set_evt(input logic [1:0] v);
		evt <= v;
	endtask

	task set_req(input logic [8:0] v);
		req <= v;
	endtask

	task set_wdt(input logic v);
		wdt <= v;
	endtask

	// Hold goes low before supplies leave limits, back up after
	task excursion(input logic on);
		if (on)
			hold_n <= 1'b0;
		else
			evt <= 2'h0;
		repeat (3) @(posedge pclk);
		if (on)
			evt <= 2'h3;
		else
			hold_n <= 1'b1;
	endtask
endmodule // supply_host_model

`default_nettype wire
